// ---- logic/kdi_pkg.sv ----
// Shared constants and types for the keypad and display two-wire target.
package kdi_pkg;
  localparam int CLK_NS = 10;
  localparam int KEY_N = 8;
  localparam int DATA_W = 8;
  localparam int REG_AW = 2;
  localparam logic [REG_AW-1:0] REG_CFG = 2'h0;
  localparam logic [REG_AW-1:0] REG_STAT = 2'h1;
  localparam logic [REG_AW-1:0] REG_KEY = 2'h2;
  localparam logic [REG_AW-1:0] REG_CTRL = 2'h3;
  localparam logic [6:0] DEF_OWN_ADDR = 7'h20;
  localparam int CMD_W = 6;
  localparam logic [CMD_W-1:0] CMD_RST = 6'h00;
  localparam int ST_MAINT = 0;
  localparam int ST_LANG = 1;
  localparam int ST_MCHG = 2;
  localparam int ST_LCHG = 3;
  localparam int ST_PEND = 4;
  localparam int ST_PWR = 5;
  localparam int ST_BUSY = 6;
  localparam logic [1:0] RD_IDX_KEY = 2'h0;
  localparam logic [1:0] RD_IDX_STAT = 2'h1;
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam int DISP_CLK_NS = 1000;
  localparam int DISP_HALF_CYC = (DISP_CLK_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int DIV_W = 8;
  localparam logic [2:0] GLYPH_COLS = 3'h5;
  localparam logic [3:0] ROT_SPAN = 4'h8;
  localparam int SYNC_W = 20;
  localparam int SCL_POS = 8;
  localparam int SDA_POS = 9;
  localparam int MAINT_POS = 10;
  localparam int LANG_POS = 11;
  localparam int SUP_POS = 12;

  typedef struct packed {
    logic dispReset;
    logic blank;
    logic beep;
    logic [2:0] lamps;
  } kdi_cmd_t;

  typedef enum logic [2:0] {
    TS_IDLE, TS_ADDR, TS_ACKA, TS_WR, TS_ACKW, TS_RD, TS_ACKR
  } kdi_tstate_t;
endpackage

// ---- logic/kdi_top.sv ----
// Keypad and display front-panel target on a two-wire serial bus.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module kdi_top #(
  parameter logic [7:0] BO_THRESH = 8'hC0,
  parameter int OFF_TIME_MS = 100,
  parameter int OFF_W = 24,
  parameter bit MAINT_FITTED = 1'b1
) (
  input wire logic core_clk, // System clock, 100 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [kdi_pkg::KEY_N-1:0] keyIn, // Key lines, high when pressed.
  input wire logic maintSwIn, // Maintenance switch level.
  input wire logic langSwIn, // Second-language switch level.
  input wire logic [7:0] supplyLevel, // Digitised display supply level.
  input wire logic sclIn, // Bus clock from host.
  input wire logic sdaIn, // Bus data level.
  output logic sdaOut, // Bus data drive value, always low.
  output logic sdaOe, // Bus data pull-down enable.
  output logic keyIntN, // Key interrupt line, active low.
  output logic keyReady, // New key word ready.
  output logic [2:0] lampOut, // Front-panel status lamps.
  output logic beeper, // Beeper drive.
  output logic [kdi_pkg::DATA_W-1:0] dispData, // Display column data.
  output logic dispClk, // Display transfer clock.
  output logic dispBlank, // Display blank.
  output logic dispResetN, // Display reset, active low.
  output logic dispPowerEn, // Display supply enable.
  output logic maintLed, // Board maintenance indicator.
  input wire logic [kdi_pkg::REG_AW-1:0] regAddr, // Register address.
  input wire logic [7:0] regWrData, // Register write data.
  input wire logic regWr, // Register write strobe.
  input wire logic regRd, // Register read strobe.
  output logic [7:0] regRdData // Register read data, one cycle after strobe.
);
  localparam logic [OFF_W-1:0] OFF_CYC = OFF_W'(OFF_TIME_MS * (1000000 / kdi_pkg::CLK_NS));
  localparam logic [kdi_pkg::DIV_W-1:0] DIV_END = kdi_pkg::DIV_W'(kdi_pkg::DISP_HALF_CYC - 1);
  localparam logic [kdi_pkg::SYNC_W-1:0] SYNC_IDLE = (kdi_pkg::SYNC_W'(1) << kdi_pkg::SCL_POS) |
                                                     (kdi_pkg::SYNC_W'(1) << kdi_pkg::SDA_POS);

  logic [kdi_pkg::SYNC_W-1:0] s1Ff, s2Ff;
  logic sclPrevFf, sdaPrevFf;
  logic [kdi_pkg::KEY_N-1:0] keyPrevFf, keyWordFf;
  logic pendingFf, maintPrevFf, langPrevFf, maintChgFf, langChgFf;
  kdi_pkg::kdi_tstate_t stFf, nxt_st;
  logic [7:0] shiftFf, nxt_shift;
  logic [3:0] bitCntFf, nxt_bitCnt;
  logic selFf, nxt_sel, rwFf, nxt_rw, hostAckFf, nxt_hostAck, nxt_sdaOe;
  logic [1:0] idxFf, nxt_idx;
  logic [6:0] ownAddrFf;
  kdi_pkg::kdi_cmd_t cmdFf;
  logic [7:0] charFf;
  logic busyFf, phaseFf;
  logic [2:0] colFf;
  logic [kdi_pkg::DIV_W-1:0] divFf;
  logic [OFF_W-1:0] offFf;

  wire logic [kdi_pkg::KEY_N-1:0] keyS = s2Ff[kdi_pkg::KEY_N-1:0];
  wire logic sclS = s2Ff[kdi_pkg::SCL_POS];
  wire logic sdaS = s2Ff[kdi_pkg::SDA_POS];
  wire logic maintS = s2Ff[kdi_pkg::MAINT_POS];
  wire logic langS = s2Ff[kdi_pkg::LANG_POS];
  wire logic [7:0] supplyS = s2Ff[kdi_pkg::SUP_POS +: 8];
  wire logic sclRise = sclS & ~sclPrevFf;
  wire logic sclFall = ~sclS & sclPrevFf;
  wire logic busStart = sclS & sclPrevFf & sdaPrevFf & ~sdaS;
  wire logic busStop = sclS & sclPrevFf & ~sdaPrevFf & sdaS;
  wire logic keyPress = |(keyS & ~keyPrevFf);
  wire logic addrMatch = shiftFf[7:2] == ownAddrFf[6:1];
  wire logic byteDone = sclFall & (bitCntFf == kdi_pkg::BITS_BYTE);
  wire logic ackSample = (stFf == kdi_pkg::TS_ACKR) & sclRise & ~sdaS;
  wire logic keyAck = ackSample & ~selFf & (idxFf == kdi_pkg::RD_IDX_KEY);
  wire logic statAck = ackSample & ~selFf & (idxFf == kdi_pkg::RD_IDX_STAT);
  wire logic cmdWrite = (stFf == kdi_pkg::TS_WR) & byteDone & ~selFf;
  wire logic charTake = (stFf == kdi_pkg::TS_WR) & byteDone & selFf & ~busyFf & dispPowerEn;
  wire logic boLow = supplyS < BO_THRESH;
  wire logic [7:0] statByte = {1'b0, busyFf, dispPowerEn, pendingFf, langChgFf, maintChgFf, langS, maintS};
  // The index of the byte about to be loaded is worked out here, so the read mux never feeds back on the FSM.
  wire logic [1:0] rdIdx = (stFf == kdi_pkg::TS_ACKR) ? idxFf + 2'h1 : kdi_pkg::RD_IDX_KEY;
  wire logic [7:0] readByte = selFf ? 8'h00 :
                              (rdIdx == kdi_pkg::RD_IDX_KEY) ? keyWordFf :
                              (rdIdx == kdi_pkg::RD_IDX_STAT) ? statByte : 8'h00;
  wire logic divTick = divFf == DIV_END;
  wire logic [15:0] charDbl = {charFf, charFf};
  wire logic [3:0] rotBase = kdi_pkg::ROT_SPAN - {1'b0, colFf};
  wire logic [7:0] colData = charDbl[rotBase +: 8];
  wire logic [7:0] regMux = (regAddr == kdi_pkg::REG_CFG) ? {1'b0, ownAddrFf} :
                            (regAddr == kdi_pkg::REG_STAT) ? statByte :
                            (regAddr == kdi_pkg::REG_KEY) ? keyWordFf : {2'h0, cmdFf};

  // Key, switch, supply and bus pins reach logic only after two stages; the first stage feeds nothing else.
  // Bus lines reset to their idle high level, so no false edge follows reset.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1Ff <= SYNC_IDLE;
      s2Ff <= SYNC_IDLE;
      sclPrevFf <= 1'b1;
      sdaPrevFf <= 1'b1;
    end
    else
    begin
      s1Ff <= {supplyLevel, langSwIn, maintSwIn, sdaIn, sclIn, keyIn};
      s2Ff <= s1Ff;
      sclPrevFf <= sclS;
      sdaPrevFf <= sdaS;
    end
  end

  // A second press while pending refreshes the word; the interrupt simply stays asserted.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      keyPrevFf <= '0;
      keyWordFf <= '0;
      pendingFf <= 1'b0;
      keyIntN <= 1'b1;
      keyReady <= 1'b0;
    end
    else
    begin
      keyPrevFf <= keyS;
      if (keyPress)
        keyWordFf <= keyS;
      pendingFf <= keyPress | (pendingFf & ~keyAck);
      keyIntN <= ~pendingFf;
      keyReady <= pendingFf;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      maintPrevFf <= 1'b0;
      langPrevFf <= 1'b0;
      maintChgFf <= 1'b0;
      langChgFf <= 1'b0;
      maintLed <= 1'b0;
    end
    else
    begin
      maintPrevFf <= maintS;
      langPrevFf <= langS;
      maintChgFf <= (maintS ^ maintPrevFf) | (maintChgFf & ~statAck);
      langChgFf <= (langS ^ langPrevFf) | (langChgFf & ~statAck);
      maintLed <= MAINT_FITTED & maintS;
    end
  end

  // Target state machine; the host owns the clock, so every step waits on its edges.
  always_comb
  begin
    nxt_st = stFf;
    nxt_shift = shiftFf;
    nxt_bitCnt = bitCntFf;
    nxt_sel = selFf;
    nxt_rw = rwFf;
    nxt_idx = idxFf;
    nxt_hostAck = hostAckFf;
    nxt_sdaOe = sdaOe;
    case (stFf)
      kdi_pkg::TS_ADDR, kdi_pkg::TS_WR:
      begin
        if (sclRise)
        begin
          nxt_shift = {shiftFf[6:0], sdaS};
          nxt_bitCnt = bitCntFf + 4'h1;
        end
        else if (byteDone && stFf == kdi_pkg::TS_ADDR)
        begin
          nxt_st = addrMatch ? kdi_pkg::TS_ACKA : kdi_pkg::TS_IDLE;
          nxt_sdaOe = addrMatch;
          nxt_sel = shiftFf[1];
          nxt_rw = shiftFf[0];
        end
        else if (byteDone)
        begin
          nxt_st = kdi_pkg::TS_ACKW;
          nxt_sdaOe = selFf ? charTake : 1'b1;
        end
      end
      kdi_pkg::TS_ACKA, kdi_pkg::TS_ACKW:
      begin
        if (sclFall)
        begin
          nxt_bitCnt = 4'h0;
          nxt_idx = kdi_pkg::RD_IDX_KEY;
          if (rwFf)
          begin
            nxt_st = kdi_pkg::TS_RD;
            nxt_shift = readByte;
            nxt_sdaOe = ~readByte[7];
          end
          else
          begin
            nxt_st = kdi_pkg::TS_WR;
            nxt_sdaOe = 1'b0;
          end
        end
      end
      kdi_pkg::TS_RD:
      begin
        if (sclFall && bitCntFf == kdi_pkg::BIT_LAST)
        begin
          nxt_st = kdi_pkg::TS_ACKR;
          nxt_sdaOe = 1'b0;
        end
        else if (sclFall)
        begin
          nxt_shift = {shiftFf[6:0], 1'b0};
          nxt_bitCnt = bitCntFf + 4'h1;
          nxt_sdaOe = ~shiftFf[6];
        end
      end
      kdi_pkg::TS_ACKR:
      begin
        if (sclRise)
          nxt_hostAck = ~sdaS;
        else if (sclFall && hostAckFf)
        begin
          nxt_st = kdi_pkg::TS_RD;
          nxt_idx = idxFf + 2'h1;
          nxt_bitCnt = 4'h0;
          nxt_shift = readByte;
          nxt_sdaOe = ~readByte[7];
        end
        else if (sclFall)
          nxt_st = kdi_pkg::TS_IDLE;
      end
      default:
        nxt_sdaOe = 1'b0;
    endcase
    if (busStart)
    begin
      nxt_st = kdi_pkg::TS_ADDR;
      nxt_bitCnt = 4'h0;
      nxt_sdaOe = 1'b0;
    end
    else if (busStop)
    begin
      nxt_st = kdi_pkg::TS_IDLE;
      nxt_sdaOe = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stFf <= kdi_pkg::TS_IDLE;
      shiftFf <= '0;
      bitCntFf <= '0;
      selFf <= 1'b0;
      rwFf <= 1'b0;
      idxFf <= '0;
      hostAckFf <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
    end
    else
    begin
      stFf <= nxt_st;
      shiftFf <= nxt_shift;
      bitCntFf <= nxt_bitCnt;
      selFf <= nxt_sel;
      rwFf <= nxt_rw;
      idxFf <= nxt_idx;
      hostAckFf <= nxt_hostAck;
      sdaOe <= nxt_sdaOe;
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ownAddrFf <= kdi_pkg::DEF_OWN_ADDR;
      cmdFf <= kdi_pkg::CMD_RST;
      regRdData <= '0;
      lampOut <= '0;
      beeper <= 1'b0;
      dispBlank <= 1'b0;
      dispResetN <= 1'b0;
    end
    else
    begin
      if (regWr && regAddr == kdi_pkg::REG_CFG)
        ownAddrFf <= regWrData[6:0];
      if (cmdWrite)
        cmdFf <= shiftFf[kdi_pkg::CMD_W-1:0];
      regRdData <= regRd ? regMux : 8'h00;
      lampOut <= cmdFf.lamps;
      beeper <= cmdFf.beep;
      dispBlank <= cmdFf.blank | ~dispPowerEn;
      dispResetN <= ~cmdFf.dispReset & dispPowerEn;
    end
  end

  // Off-time restarts on every dip, so a flickering supply keeps the panel dark.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      offFf <= '0;
      dispPowerEn <= 1'b0;
    end
    else
    begin
      offFf <= boLow ? OFF_CYC : (offFf != '0) ? offFf - OFF_W'(1) : offFf;
      dispPowerEn <= ~boLow & (offFf == '0);
    end
  end

  // One character at a time; a character sent while busy is refused with a not-acknowledge.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      charFf <= '0;
      busyFf <= 1'b0;
      phaseFf <= 1'b0;
      colFf <= '0;
      divFf <= '0;
      dispClk <= 1'b0;
      dispData <= '0;
    end
    else
    begin
      divFf <= (divTick || !busyFf) ? '0 : divFf + kdi_pkg::DIV_W'(1);
      if (charTake)
      begin
        charFf <= shiftFf;
        busyFf <= 1'b1;
        colFf <= '0;
        phaseFf <= 1'b0;
      end
      else if (!dispPowerEn)
      begin
        busyFf <= 1'b0;
        dispClk <= 1'b0;
      end
      else if (busyFf && divTick)
      begin
        phaseFf <= ~phaseFf;
        dispClk <= ~phaseFf;
        if (!phaseFf)
          dispData <= colData;
        else if (colFf == kdi_pkg::GLYPH_COLS - 3'h1)
          busyFf <= 1'b0;
        else
          colFf <= colFf + 3'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_press_pend;
    keyPress |=> pendingFf ##1 !keyIntN;
  endproperty
  a_press_pend: assert property (p_press_pend) else $error("Press did not raise interrupt.");
  property p_word;
    keyPress |=> keyWordFf == $past(keyS);
  endproperty
  a_word: assert property (p_word) else $error("Key word not captured.");
  property p_hold;
    pendingFf && !keyAck && !keyPress |=> pendingFf && $stable(keyWordFf);
  endproperty
  a_hold: assert property (p_hold) else $error("Pending key lost without acknowledge.");
  property p_ack;
    keyAck && !keyPress |=> !pendingFf ##1 keyIntN && !keyReady;
  endproperty
  a_ack: assert property (p_ack) else $error("Acknowledge did not clear interrupt.");
  property p_ready;
    keyReady == !keyIntN;
  endproperty
  a_ready: assert property (p_ready) else $error("Ready and interrupt disagree.");
  property p_nomatch;
    stFf == kdi_pkg::TS_ADDR && byteDone && !addrMatch && !busStart |=> !sdaOe [*2];
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("Answered a foreign address.");
  property p_brown;
    boLow |=> !dispPowerEn ##1 !dispResetN;
  endproperty
  a_brown: assert property (p_brown) else $error("Display not cut on brown-out.");
  property p_offhold;
    $fell(dispPowerEn) |-> !dispPowerEn [*4];
  endproperty
  a_offhold: assert property (p_offhold) else $error("Display off-time too short.");
  property p_maint;
    maintS != maintPrevFf |=> maintChgFf ##1 maintLed == (MAINT_FITTED & $past(maintS));
  endproperty
  a_maint: assert property (p_maint) else $error("Maintenance change not reported.");
  property p_dclk;
    $rose(dispClk) |-> $past(busyFf) && $past(dispPowerEn);
  endproperty
  a_dclk: assert property (p_dclk) else $error("Display clock outside a transfer.");
  property p_cmd;
    cmdWrite |=> cmdFf == $past(shiftFf[kdi_pkg::CMD_W-1:0]) ##1 lampOut == cmdFf.lamps;
  endproperty
  a_cmd: assert property (p_cmd) else $error("Command not applied.");

  c_press: cover property (keyPress ##[1:200] keyAck);
  c_char: cover property (charTake ##[1:1000] !busyFf);
  c_brown: cover property ($fell(dispPowerEn) ##[1:1000] $rose(dispPowerEn));
  c_read: cover property (statAck);
endmodule

// ---- sim/kdi_host_model.sv ----
// Behavioural host that masters the two-wire bus at an 80 ns bus clock period.
`timescale 1ns/1ps
module kdi_host_model (
  output logic scl, // Bus clock, owned by the host.
  output logic sdaLow, // High while the host pulls the data wire low.
  input wire logic sdaWire // Resolved data wire level.
);
  localparam int Q = 20;

  // The clock stands high between frames, as an idle bus does.
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic startBit();
    scl = 1'b1;
    sdaLow = 1'b0;
    #Q;
    sdaLow = 1'b1;
    #Q;
    scl = 1'b0;
  endtask

  task automatic stopBit();
    #Q;
    sdaLow = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sdaLow = 1'b0;
    #Q;
  endtask

  // Data is set mid-low and sampled at the end of the high phase, giving the target most margin.
  task automatic bitIo(input logic b, output logic r);
    #Q;
    sdaLow = !b;
    #Q;
    scl = 1'b1;
    #(2 * Q);
    r = sdaWire;
    scl = 1'b0;
  endtask

  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = !r;
  endtask

  task automatic byteIn(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(1'b1, r);
      d[i] = r;
    end
    bitIo(!ackIt, r);
  endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the keypad and display two-wire target.
`timescale 1ns/1ps
module testbench;
  logic coreClk, arstN, maintSw, langSw, regWr, regRd;
  logic [7:0] keys, supply, regWrData, rd, d, cmd, ch;
  logic [1:0] regAddr;
  logic sdaOut, sdaOe, keyIntN, keyReady, beeper, dispClk, dispBlank, dispResetN, dispPowerEn, maintLed;
  logic [2:0] lampOut;
  logic [7:0] dispData, regRdData;
  logic scl, hostLow, ack;
  wire logic sdaWire = !sdaOe && !hostLow;
  int errCount = 0;
  int testsRun = 0;
  int cyc = 0;
  int n;

  kdi_top #(.OFF_TIME_MS(0)) u_dut (.core_clk(coreClk), .arst_n(arstN), .keyIn(keys), .maintSwIn(maintSw),
    .langSwIn(langSw), .supplyLevel(supply), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .keyIntN(keyIntN), .keyReady(keyReady), .lampOut(lampOut), .beeper(beeper), .dispData(dispData),
    .dispClk(dispClk), .dispBlank(dispBlank), .dispResetN(dispResetN), .dispPowerEn(dispPowerEn),
    .maintLed(maintLed), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData));
  kdi_host_model u_host (.scl(scl), .sdaLow(hostLow), .sdaWire(sdaWire));

  initial
  begin
    coreClk = 1'b0;
    forever #5 coreClk = !coreClk;
  end

  task automatic finalReport();
    if (errCount == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // The whole sequence needs well under 20000 cycles; a hang is cut short here.
  always @(posedge coreClk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errCount++;
      finalReport();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic regWrite(input logic [1:0] a, input logic [7:0] v);
    @(posedge coreClk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge coreClk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [1:0] a, output logic [7:0] v);
    @(posedge coreClk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge coreClk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
  endtask

  task automatic waitCycles(input int c);
    repeat (c) @(posedge coreClk);
    #3;
  endtask

  function automatic logic [7:0] rotl(input logic [7:0] v, input int c);
    return (v << c) | (v >> (8 - c));
  endfunction

  task automatic busWrite(input logic [7:0] a, input logic [7:0] v, output logic ok);
    logic k;
    waitCycles(1);
    u_host.startBit();
    // The data byte goes out even when the address is refused, so ignored traffic is really exercised.
    u_host.byteOut(a, ok);
    u_host.byteOut(v, k);
    ok = ok & k;
    u_host.stopBit();
    waitCycles(8);
  endtask

  initial
  begin
    arstN = 1'b0;
    keys = 8'h00;
    maintSw = 1'b0;
    langSw = 1'b0;
    supply = 8'hFF;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 2'h0;
    regWrData = 8'h00;
    void'($urandom(32'he47b));
    repeat (10) @(posedge coreClk);
    arstN <= 1'b1;
    check({7'h00, keyIntN}, 8'h01);
    regRead(kdi_pkg::REG_CFG, rd);
    check(rd, {1'b0, kdi_pkg::DEF_OWN_ADDR});
    for (n = 0; n < 100 && dispPowerEn !== 1'b1; n++) @(posedge coreClk);
    check({7'h00, dispPowerEn}, 8'h01);
    // Supply dip one step under the threshold, then back exactly at it.
    @(posedge coreClk);
    supply <= 8'hBF;
    waitCycles(20);
    check({5'h00, dispPowerEn, dispBlank, dispResetN}, 8'h02);
    supply <= 8'hC0;
    for (n = 0; n < 100 && dispPowerEn !== 1'b1; n++) @(posedge coreClk);
    check({7'h00, dispPowerEn}, 8'h01);
    // Key press, held across the host's read and acknowledge.
    @(posedge coreClk);
    keys <= 8'($urandom) | 8'h81;
    for (n = 0; n < 20 && keyIntN !== 1'b0; n++) @(posedge coreClk);
    check({6'h00, keyIntN, keyReady}, 8'h01);
    regRead(kdi_pkg::REG_KEY, rd);
    check(rd, keys);
    waitCycles(50);
    check({7'h00, keyIntN}, 8'h00);
    waitCycles(1);
    u_host.startBit();
    u_host.byteOut({kdi_pkg::DEF_OWN_ADDR, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    u_host.byteIn(1'b1, d);
    check(d, keys);
    u_host.byteIn(1'b0, d);
    check(d & 8'h33, 8'h20);
    u_host.stopBit();
    waitCycles(50);
    check({7'h00, keyIntN}, 8'h01);
    @(posedge coreClk);
    keys <= 8'h00;
    // Commands: random lamp, beeper and blank settings, then a display reset, then all off.
    for (int i = 0; i < 6; i++)
    begin
      cmd = (i == 4) ? 8'h20 : (i == 5) ? 8'h00 : {3'b000, 5'($urandom)};
      busWrite({kdi_pkg::DEF_OWN_ADDR, 1'b0}, cmd, ack);
      check({7'h00, ack}, 8'h01);
      check({2'b00, !dispResetN, dispBlank, beeper, lampOut}, cmd);
      regRead(kdi_pkg::REG_CTRL, rd);
      check(rd, cmd);
    end
    // A foreign address is not answered and changes nothing.
    busWrite(8'h60, 8'h1F, ack);
    check({7'h00, ack, 3'b000, beeper, lampOut}, 8'h00);
    // Moving our own address moves the answered pair; the key register ignores writes.
    regWrite(kdi_pkg::REG_CFG, 8'h22);
    regWrite(kdi_pkg::REG_KEY, 8'hFF);
    regRead(kdi_pkg::REG_CFG, rd);
    check(rd, 8'h22);
    busWrite({kdi_pkg::DEF_OWN_ADDR, 1'b0}, 8'h07, ack);
    check({3'h0, ack, 1'b0, lampOut}, 8'h00);
    busWrite(8'h44, 8'h07, ack);
    check({3'h0, ack, 1'b0, lampOut}, 8'h17);
    regWrite(kdi_pkg::REG_CFG, 8'h20);
    busWrite({kdi_pkg::DEF_OWN_ADDR, 1'b0}, 8'h00, ack);
    // Both switches close, are read and cleared over the bus, then both open again.
    @(posedge coreClk);
    maintSw <= 1'b1;
    langSw <= 1'b1;
    waitCycles(10);
    regRead(kdi_pkg::REG_STAT, rd);
    check(rd & 8'h0F, 8'h0F);
    check({7'h00, maintLed}, 8'h01);
    waitCycles(1);
    u_host.startBit();
    u_host.byteOut({kdi_pkg::DEF_OWN_ADDR, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    u_host.byteIn(1'b1, d);
    u_host.byteIn(1'b1, d);
    check(d & 8'h0F, 8'h0F);
    u_host.byteIn(1'b0, d);
    check(d, 8'h00);
    u_host.stopBit();
    waitCycles(8);
    check({7'h00, sdaOut}, 8'h00);
    regRead(kdi_pkg::REG_STAT, rd);
    check(rd & 8'h0F, 8'h03);
    @(posedge coreClk);
    maintSw <= 1'b0;
    langSw <= 1'b0;
    waitCycles(10);
    regRead(kdi_pkg::REG_STAT, rd);
    check(rd & 8'h0F, 8'h0C);
    check({7'h00, maintLed}, 8'h00);
    // One character becomes columns, each the character rotated by its column index.
    ch = 8'($urandom) | 8'h41;
    busWrite({kdi_pkg::DEF_OWN_ADDR | 7'h01, 1'b0}, ch, ack);
    check({7'h00, ack}, 8'h01);
    for (int c = 0; c < 2; c++)
    begin
      for (n = 0; n < 2000 && dispClk !== 1'b0; n++) @(posedge coreClk);
      for (n = 0; n < 2000 && dispClk !== 1'b1; n++) @(posedge coreClk);
      check({7'h00, dispClk}, 8'h01);
      check(dispData, rotl(ch, c));
    end
    // The panel is still drawing, so a second character is refused.
    busWrite({kdi_pkg::DEF_OWN_ADDR | 7'h01, 1'b0}, ch, ack);
    check({7'h00, ack}, 8'h00);
    finalReport();
  end
endmodule
